// file: oap_defs.vh
// Behaviour
// RULE_01 - read-protect key field must equal fixed constant, otherwise level two applies
// RULE_02 - level field 11 gives level zero, no restriction for anyone
// RULE_03 - level field 10: debug denied except bulk erase; flash and ram fetch full
// RULE_04 - level field 0x: only flash fetch may access; others bulk erase only
// RULE_05 - protection level may only rise, never be lowered
// RULE_06 - option page 1 erase blocked for debug at levels 1-2, ram at 2
// RULE_07 - option area stays readable at levels one and two
// RULE_08 - level two: ram fetch page erase/write refused, bulk erase allowed
// RULE_09 - levels one and two: debug page erase/write refused, bulk allowed
// RULE_10 - after bulk erase completes the level is zero
// RULE_11 - osc master field selects software, forced-on-no-deep-sleep, or forced on
// RULE_12 - software uses only sleep when oscillator clocks core and not software code
// RULE_13 - clock master bit one forces watchdog oscillator as watchdog clock
// RULE_14 - reset master bit zero forces watchdog reset, one defers to software
// RULE_15 - counter master bit zero forces watchdog counter, one defers to software
// RULE_16 - undervolt option word honoured only with 16-bit key in upper half
// RULE_17 - undervolt master code lets software decide, else forced on
// RULE_18 - three-bit threshold select picks one of eight trip voltages
// RULE_19 - option page guard bits 0..2 guard pages 1..3, zero blocks
// RULE_20 - protected option page refuses page-unit erase
// RULE_21 - one guard bit per code sector 0..63, zero blocks erase/write
// RULE_22 - data sector guard bits 0..7, zero blocks erase/write
// RULE_23 - data sector guard bit one permits erase/write
// RULE_24 - option words latched after reset before flash access is granted
`ifndef OAP_DEFS_VH
`define OAP_DEFS_VH
// ************************************************************
// option word addresses (byte addresses on the bus)
// ************************************************************
`define OAP_A_TSF105   32'h1FFFF06C
`define OAP_A_DIEXY    32'h1FFFF050
`define OAP_A_LOTWAF   32'h1FFFF054
`define OAP_A_LOTMID   32'h1FFFF058
`define OAP_A_LOTHI    32'h1FFFF05C
`define OAP_A_RDPROT   32'h1FFFF200
`define OAP_A_WDOG     32'h1FFFF20C
`define OAP_A_UVOLT    32'h1FFFF210
`define OAP_A_PGPROT   32'h1FFFF214
`define OAP_A_CSLO     32'h1FFFF240
`define OAP_A_CSHI     32'h1FFFF244
`define OAP_A_DSPROT   32'h1FFFF270
// ************************************************************
// block status / control registers (own offsets)
// ************************************************************
`define OAP_A_STATUS   32'h1FFFF300
`define OAP_A_LVLREQ   32'h1FFFF304
// ************************************************************
// keys and codes
// ************************************************************
`define OAP_RP_KEY     28'h69C8A27
`define OAP_UV_KEY     16'h9D58
`define OAP_OSC_SW     12'h96D
`define OAP_OSC_NODS   12'h2A7
`define OAP_UV_SW      8'hAA
// ************************************************************
// load sequence
// ************************************************************
`define OAP_NWORDS     4'hC
`define OAP_UV_DEF_THR 3'h7
`endif

// file: oap_loader.v
`timescale 1ns/1ps
// fetches option words one by one from flash after reset
module oap_loader #(
	parameter NW = 12
) (
	input  wire        clk_i,
	input  wire        rst_b_i,
	output reg  [3:0]  idx_o,
	output reg         req_o,
	input  wire        ack_i,
	output wire        cap_o,
	output reg         done_o
);
	// ************************************************************
	// sequencer
	// ************************************************************
	assign cap_o = req_o & ack_i;
	// step through word indices, one request per word
	always @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			idx_o  <= 4'h0;
			req_o  <= 1'b0;
			done_o <= 1'b0;
		end else if (!done_o) begin
			req_o <= 1'b1;
			if (cap_o) begin
				if (idx_o == NW - 1) begin
					done_o <= 1'b1; // see RULE_24
					req_o  <= 1'b0;
				end else begin
					idx_o <= idx_o + 4'h1;
				end
			end
		end
	end
endmodule // oap_loader

// file: oap_top.v
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/1ps
`include "oap_defs.vh"
module oap_top (
	input  wire        clk_i,
	input  wire        rst_b_i,
	// option word fetch from flash
	output wire [31:0] opt_addr_o,
	output wire        opt_req_o,
	input  wire        opt_ack_i,
	input  wire [31:0] opt_data_i,
	// access check from flash controller
	input  wire        acc_req_i,
	input  wire [1:0]  acc_src_i,   // 0 flash fetch, 1 ram fetch, 2 debug
	input  wire [1:0]  acc_op_i,    // 0 read, 1 page erase, 2 write, 3 bulk
	input  wire [1:0]  acc_area_i,  // 0 code, 1 data, 2 option area
	input  wire [5:0]  acc_sect_i,  // sector, or option page number
	output wire        acc_ok_o,
	input  wire        bulk_done_i,
	output wire        access_ready_o,
	output wire [1:0]  prot_level_o,
	// watchdog overrides
	input  wire        wdog_osc_sw_enable_i,
	input  wire        deep_sleep_i,
	input  wire        shutdown_i,
	input  wire        wdog_clk_sw_sel_i,
	input  wire [5:0]  wdog_reset_sw_enable_i,
	input  wire [5:0]  wdog_counter_sw_enable_i,
	output wire        wdog_rc_osc_on_o,
	output wire        wdog_clk_sel_o,
	output wire        wdog_reset_en_o,
	output wire        wdog_counter_en_o,
	// undervolt reset
	input  wire        undervolt_sw_enable_i,
	output wire        undervolt_reset_en_o,
	output wire [2:0]  undervolt_threshold_sel_o,
	// axi4-lite slave
	input  wire [31:0] s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [31:0] s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready
);
	// source, operation and area codes of an access check
	localparam SRC_FL = 2'h0;
	localparam SRC_RAM = 2'h1;
	localparam SRC_DBG = 2'h2;
	localparam OP_RD = 2'h0;
	localparam OP_BULK = 2'h3;
	localparam AR_CODE = 2'h0;
	localparam AR_DATA = 2'h1;
	localparam AR_OPT = 2'h2;

	// ************************************************************
	// option word latch
	// ************************************************************
	// loader handshake and the latched option words
	wire [3:0]  ld_idx;
	wire        ld_cap;
	wire        ld_done;
	wire [31:0] opt_r [0:11];
	reg  [31:0] addr_tab;

	oap_loader #(.NW(`OAP_NWORDS)) u_ld (
		.clk_i   (clk_i),
		.rst_b_i (rst_b_i),
		.idx_o   (ld_idx),
		.req_o   (opt_req_o),
		.ack_i   (opt_ack_i),
		.cap_o   (ld_cap),
		.done_o  (ld_done)
	);

	// index to option word address
	always @* begin
		case (ld_idx)
		4'h0: addr_tab = `OAP_A_TSF105;
		4'h1: addr_tab = `OAP_A_DIEXY;
		4'h2: addr_tab = `OAP_A_LOTWAF;
		4'h3: addr_tab = `OAP_A_LOTMID;
		4'h4: addr_tab = `OAP_A_LOTHI;
		4'h5: addr_tab = `OAP_A_RDPROT;
		4'h6: addr_tab = `OAP_A_WDOG;
		4'h7: addr_tab = `OAP_A_UVOLT;
		4'h8: addr_tab = `OAP_A_PGPROT;
		4'h9: addr_tab = `OAP_A_CSLO;
		4'hA: addr_tab = `OAP_A_CSHI;
		default: addr_tab = `OAP_A_DSPROT;
		endcase
	end
	assign opt_addr_o = addr_tab;

	// words reset to all-zero: most restrictive until loaded
	genvar gi;
	generate
		for (gi = 0; gi < 12; gi = gi + 1) begin : g_opt
			reg [31:0] word_r;
			always @(posedge clk_i or negedge rst_b_i) begin
				if (!rst_b_i)
					word_r <= 32'h00000000;
				else if (ld_cap && ld_idx == gi)
					word_r <= opt_data_i; // see RULE_24
			end
			assign opt_r[gi] = word_r;
		end
	endgenerate

	// option words by role: protect, watchdog, undervolt, guards
	wire [31:0] w_rp = opt_r[5];
	wire [31:0] w_wd = opt_r[6];
	wire [31:0] w_uv = opt_r[7];
	wire [31:0] w_pg = opt_r[8];
	wire [63:0] code_sector_guard = {opt_r[10], opt_r[9]};
	wire [7:0]  data_sector_guard = opt_r[11][7:0];

	// ************************************************************
	// protection level
	// ************************************************************
	// key and level fields, decoded level and live level
	wire [27:0] option_key_field = w_rp[31:4];
	wire [1:0]  protection_level_field = w_rp[1:0];
	reg  [1:0]  dec_lvl;
	reg  [1:0]  lvl_r;
	reg  [1:0]  lvl_nxt;
	reg         wr_lvl;
	reg  [1:0]  wr_lvl_val;

	// decode stored option word into level 0/1/2
	always @* begin
		if (option_key_field != `OAP_RP_KEY)
			dec_lvl = 2'h2;                            // see RULE_01
		else if (protection_level_field == 2'h3)
			dec_lvl = 2'h0;                            // see RULE_02
		else if (protection_level_field == 2'h2)
			dec_lvl = 2'h1;                            // see RULE_03
		else
			dec_lvl = 2'h2;                            // see RULE_04
	end

	// level only rises; bulk erase returns to zero
	// code 3 is not a level, so a request for it is dropped
	always @* begin
		lvl_nxt = lvl_r;
		if (bulk_done_i)
			lvl_nxt = 2'h0;                            // see RULE_10
		else if (wr_lvl && wr_lvl_val > lvl_r && wr_lvl_val != 2'h3)
			lvl_nxt = wr_lvl_val;                      // see RULE_05
	end

	// level register, loaded from option word at end of fetch
	reg  ld_done_d;
	wire ld_fire;
	// one-cycle strobe once the last word has been latched
	assign ld_fire = ld_done & ~ld_done_d;
	always @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			lvl_r     <= 2'h2;
			ld_done_d <= 1'b0;
		end else begin
			ld_done_d <= ld_done;
			// a bulk erase in the load cycle still wins
			if (ld_fire && !bulk_done_i)
				lvl_r <= dec_lvl;                  // see RULE_10
			else
				lvl_r <= lvl_nxt;
		end
	end
	// level and readiness as seen by the flash controller
	assign prot_level_o   = lvl_r;
	assign access_ready_o = ld_done_d;             // see RULE_24

	// ************************************************************
	// access check
	// ************************************************************
	// pg_ok: guard bit of the addressed sector or option page
	reg ok;
	reg pg_ok;
	// combine level, source and guard bits
	always @* begin
		pg_ok = 1'b1;
		case (acc_area_i)
		AR_CODE: pg_ok = code_sector_guard[acc_sect_i];        // see RULE_21
		AR_DATA: pg_ok = data_sector_guard[acc_sect_i[2:0]];   // see RULE_22
		default: begin
			case (acc_sect_i[1:0])
			2'h1: pg_ok = w_pg[0];                     // see RULE_19
			2'h2: pg_ok = w_pg[1];                     // see RULE_19
			2'h3: pg_ok = w_pg[2];                     // see RULE_20
			default: pg_ok = 1'b0;
			endcase
		end
		endcase
		// level and source limits come before the guard bits
		if (!ld_done_d)
			ok = 1'b0;
		else if (acc_op_i == OP_BULK)
			ok = 1'b1;                                 // see RULE_08
		else if (acc_op_i == OP_RD)
			ok = (lvl_r == 2'h0) || (acc_src_i == SRC_FL) ||
			     (acc_area_i == AR_OPT) ||             // see RULE_07
			     (lvl_r == 2'h1 && acc_src_i == SRC_RAM);
		else if (acc_src_i == SRC_DBG && lvl_r != 2'h0)
			ok = 1'b0;                                 // see RULE_09
		else if (acc_src_i == SRC_RAM && lvl_r == 2'h2)
			ok = 1'b0;                                 // see RULE_06
		else
			ok = pg_ok;                                // see RULE_23
	end
	assign acc_ok_o = acc_req_i & ok;

	// ************************************************************
	// watchdog and undervolt overrides
	// ************************************************************
	// watchdog master fields of the watchdog option word
	wire [11:0] wdog_osc_master_field = w_wd[15:4];
	wire        wdog_clock_master_bit = w_wd[2];
	wire        wdog_reset_master_bit = w_wd[1];
	wire        wdog_counter_master_bit = w_wd[0];
	// oscillator master decode
	assign wdog_rc_osc_on_o =
		(wdog_osc_master_field == `OAP_OSC_SW)   ? wdog_osc_sw_enable_i :
		(wdog_osc_master_field == `OAP_OSC_NODS) ? ~deep_sleep_i :
		~shutdown_i;                                   // see RULE_11
	assign wdog_clk_sel_o = wdog_clock_master_bit | wdog_clk_sw_sel_i; // see RULE_13
	assign wdog_reset_en_o = ~wdog_reset_master_bit |
		(|wdog_reset_sw_enable_i);                     // see RULE_14
	assign wdog_counter_en_o = ~wdog_counter_master_bit |
		(|wdog_counter_sw_enable_i);                   // see RULE_15

	// undervolt word counts only with its key in the upper half
	wire uv_key_ok = (w_uv[31:16] == `OAP_UV_KEY);     // see RULE_16
	wire [7:0] undervolt_master_field = w_uv[15:8];
	// without key, undervolt stays forced on at lowest trip point
	assign undervolt_reset_en_o = (uv_key_ok &&
		undervolt_master_field == `OAP_UV_SW) ?
		undervolt_sw_enable_i : 1'b1;                  // see RULE_17
	assign undervolt_threshold_sel_o = uv_key_ok ? w_uv[2:0] :
		`OAP_UV_DEF_THR;                               // see RULE_18

	// ************************************************************
	// axi4-lite slave
	// ************************************************************
	// held write address, data and strobes
	reg        aw_h;
	reg        w_h;
	reg [31:0] aw_r;
	reg [31:0] wd_r;
	reg [3:0]  ws_r;
	// no new write while one is held or still answered
	assign s_axi_awready = ~aw_h & ~s_axi_bvalid;
	assign s_axi_wready  = ~w_h & ~s_axi_bvalid;
	assign s_axi_arready = ~s_axi_rvalid;

	// level request register write decode
	always @* begin
		wr_lvl     = aw_h && w_h && !s_axi_bvalid &&
		             aw_r == `OAP_A_LVLREQ && ws_r[0];
		wr_lvl_val = wd_r[1:0];
	end

	// write channel: hold address and data, answer once both seen
	always @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			aw_h <= 1'b0;
			w_h  <= 1'b0;
			aw_r <= 32'h00000000;
			wd_r <= 32'h00000000;
			ws_r <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= 2'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_h <= 1'b1;
				aw_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_h  <= 1'b1;
				wd_r <= s_axi_wdata;
				ws_r <= s_axi_wstrb;
			end
			if (aw_h && w_h && !s_axi_bvalid) begin
				// only the level request word takes a write
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (aw_r == `OAP_A_LVLREQ) ? 2'h0 : 2'h2;
				aw_h <= 1'b0;
				w_h  <= 1'b0;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// read channel: option words, status, level
	reg [31:0] rd_v;
	reg        rd_ok;
	always @* begin
		rd_ok = 1'b1;
		case (s_axi_araddr)
		`OAP_A_TSF105: rd_v = opt_r[0];
		`OAP_A_DIEXY:  rd_v = opt_r[1];
		`OAP_A_LOTWAF: rd_v = opt_r[2];
		`OAP_A_LOTMID: rd_v = opt_r[3];
		`OAP_A_LOTHI:  rd_v = opt_r[4];
		`OAP_A_RDPROT: rd_v = opt_r[5];
		`OAP_A_WDOG:   rd_v = opt_r[6];
		`OAP_A_UVOLT:  rd_v = opt_r[7];
		`OAP_A_PGPROT: rd_v = opt_r[8];
		`OAP_A_CSLO:   rd_v = opt_r[9];
		`OAP_A_CSHI:   rd_v = opt_r[10];
		`OAP_A_DSPROT: rd_v = opt_r[11];
		`OAP_A_STATUS: rd_v = {29'h0, ld_done_d, lvl_r};
		`OAP_A_LVLREQ: rd_v = {30'h0, lvl_r};
		default: begin
			// unmapped: zero data and a slave error
			rd_v  = 32'h00000000;
			rd_ok = 1'b0;
		end
		endcase
	end

	// read answer registered on the same edge that takes the address
	always @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= 2'h0;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_v;
			s_axi_rresp  <= rd_ok ? 2'h0 : 2'h2;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule // oap_top

// file: oap_flash_model.sv
`timescale 1ns/1ps
`include "oap_defs.vh"
// flash side: answers option word fetches from a word table keyed by address
module oap_flash_model (
	input  wire        clk_i,
	input  wire        rst_b_i,
	input  wire [31:0] addr_i,
	input  wire        req_i,
	input  wire        slow_i,
	output reg         ack_o,
	output reg  [31:0] data_o
);
	// ************************************************************
	// word store and answer
	// ************************************************************
	logic [31:0] mem [logic [31:0]];
	logic        tog_r;

	// one word per ack, at most every other cycle; slow mode also waits for tog_r, which falls in step with those acks
	always @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ack_o  <= 1'b0;
			data_o <= 32'h0;
			tog_r  <= 1'b0;
		end else begin
			tog_r <= ~tog_r;
			if (req_i && !ack_o && (!slow_i || tog_r)) begin
				ack_o  <= 1'b1;
				// unwritten words read as erased flash
				data_o <= mem.exists(addr_i) ? mem[addr_i] : 32'hFFFFFFFF;
			end else begin
				ack_o  <= 1'b0;
				data_o <= ~data_o; // stale data never looks valid
			end
		end
	end
endmodule // oap_flash_model

// file: oap_chk_properties.sv
`timescale 1ns/1ps
// watches access decisions and level moves at the top ports
module oap_chk (
	input wire       clk_i,
	input wire       rst_b_i,
	input wire       acc_req_i,
	input wire [1:0] acc_src_i,
	input wire [1:0] acc_op_i,
	input wire [1:0] acc_area_i,
	input wire       acc_ok_o,
	input wire       bulk_done_i,
	input wire       access_ready_o,
	input wire [1:0] prot_level_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	wire go = acc_req_i && access_ready_o; // a live check request

	// ************************************************************
	// access decisions
	// ************************************************************
	AST_RDY: assert property (!access_ready_o |-> !acc_ok_o)
		else $error("grant before option words loaded");
	AST_REQ: assert property (acc_ok_o |-> acc_req_i)
		else $error("grant without request");
	AST_BULK: assert property (go && acc_op_i == 2'h3 |-> acc_ok_o)
		else $error("bulk erase refused");
	AST_L0RD: assert property (go && prot_level_o == 2'h0
		&& acc_op_i == 2'h0 |-> acc_ok_o) else $error("open level read refused");
	AST_DBG: assert property (go && acc_src_i == 2'h2 && prot_level_o != 2'h0
		&& acc_op_i inside {2'h1, 2'h2} |-> !acc_ok_o)
		else $error("debug page change granted");
	AST_RAM: assert property (go && acc_src_i == 2'h1 && prot_level_o == 2'h2
		&& acc_op_i inside {2'h1, 2'h2} |-> !acc_ok_o)
		else $error("ram fetch page change granted");
	AST_FLRD: assert property (go && acc_src_i == 2'h0
		&& acc_op_i == 2'h0 |-> acc_ok_o) else $error("flash fetch read refused");
	AST_OPTRD: assert property (go && acc_area_i == 2'h2
		&& acc_op_i == 2'h0 |-> acc_ok_o) else $error("option read refused");

	// ************************************************************
	// level movement
	// ************************************************************
	AST_BULKDONE: assert property (bulk_done_i |=> prot_level_o == 2'h0)
		else $error("level not cleared by bulk erase");
	AST_UP: assert property (access_ready_o && $past(access_ready_o)
		&& !$past(bulk_done_i) |-> prot_level_o >= $past(prot_level_o))
		else $error("level lowered");
endmodule // oap_chk

bind oap_top oap_chk chk_u (.clk_i, .rst_b_i, .acc_req_i, .acc_src_i,
	.acc_op_i, .acc_area_i, .acc_ok_o, .bulk_done_i, .access_ready_o,
	.prot_level_o);

// file: oap_tb.sv
`timescale 1ns/1ps
`include "oap_defs.vh"
module tb;
	logic        clk_i, rst_b_i, opt_ack_i, acc_req_i, bulk_done_i, slow;
	logic        wdog_osc_sw_enable_i, deep_sleep_i, shutdown_i;
	logic        wdog_clk_sw_sel_i, undervolt_sw_enable_i;
	logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic        s_axi_arvalid, s_axi_rready;
	logic [1:0]  acc_src_i, acc_op_i, acc_area_i;
	logic [5:0]  acc_sect_i, wdog_reset_sw_enable_i, wdog_counter_sw_enable_i;
	logic [3:0]  s_axi_wstrb;
	logic [31:0] opt_data_i, s_axi_awaddr, s_axi_wdata, s_axi_araddr;
	wire  [31:0] opt_addr_o, s_axi_rdata;
	wire         opt_req_o, acc_ok_o, access_ready_o, wdog_rc_osc_on_o;
	wire         wdog_clk_sel_o, wdog_reset_en_o, wdog_counter_en_o;
	wire         undervolt_reset_en_o, s_axi_awready, s_axi_wready;
	wire         s_axi_arready, s_axi_bvalid, s_axi_rvalid;
	wire  [1:0]  prot_level_o, s_axi_bresp, s_axi_rresp;
	wire  [2:0]  undervolt_threshold_sel_o;
	int          err_total, check_count;

	oap_top dut_u (.clk_i, .rst_b_i, .opt_addr_o, .opt_req_o, .opt_ack_i,
		.opt_data_i, .acc_req_i, .acc_src_i, .acc_op_i, .acc_area_i,
		.acc_sect_i, .acc_ok_o, .bulk_done_i, .access_ready_o, .prot_level_o,
		.wdog_osc_sw_enable_i, .deep_sleep_i, .shutdown_i, .wdog_clk_sw_sel_i,
		.wdog_reset_sw_enable_i, .wdog_counter_sw_enable_i, .wdog_rc_osc_on_o,
		.wdog_clk_sel_o, .wdog_reset_en_o, .wdog_counter_en_o,
		.undervolt_sw_enable_i, .undervolt_reset_en_o,
		.undervolt_threshold_sel_o, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	oap_flash_model fl_u (.clk_i, .rst_b_i, .addr_i(opt_addr_o),
		.req_i(opt_req_o), .slow_i(slow), .ack_o(opt_ack_i),
		.data_o(opt_data_i));

	// ************************************************************
	// clock, watchdog and shared tasks
	// ************************************************************
	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end
	// cut a hang short
	initial begin
		#300us;
		err_total++;
		complete_run();
	end
	task automatic complete_run();
		if (err_total == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic cmp(string nm, logic [31:0] e, logic [31:0] g);
		check_count++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	// fill the protect, watchdog and undervolt words, reset for 5 cycles, wait for the load
	task automatic load(logic [31:0] rp, wd, uv);
		fl_u.mem[`OAP_A_RDPROT] = rp;
		fl_u.mem[`OAP_A_WDOG] = wd;
		fl_u.mem[`OAP_A_UVOLT] = uv;
		@(posedge clk_i);
		rst_b_i <= 1'b0;
		repeat (5) @(posedge clk_i);
		rst_b_i <= 1'b1;
		for (int n = 0; n < 200 && access_ready_o !== 1'b1; n++)
			@(negedge clk_i);
		cmp("ready", 32'h1, access_ready_o);
	endtask
	task automatic acc(logic [1:0] s, o, a, logic [5:0] n, logic e);
		@(posedge clk_i);
		acc_req_i <= 1'b1;
		acc_src_i <= s;
		acc_op_i <= o;
		acc_area_i <= a;
		acc_sect_i <= n;
		@(negedge clk_i);
		cmp("acc_ok", e, acc_ok_o);
	endtask
	task automatic wr(logic [31:0] a, d, logic [1:0] e);
		logic aw, w, b;
		logic [1:0] br;
		b = 1'b0;
		@(posedge clk_i);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!b) begin
			@(negedge clk_i);
			aw = s_axi_awready;
			w = s_axi_wready;
			b = s_axi_bvalid;
			br = s_axi_bresp;
			@(posedge clk_i);
			if (aw) s_axi_awvalid <= 1'b0;
			if (w) s_axi_wvalid <= 1'b0;
		end
		s_axi_bready <= 1'b0;
		cmp("bresp", e, br);
	endtask
	task automatic rd(logic [31:0] a, d, logic [1:0] e);
		logic ar, r;
		logic [31:0] dd;
		logic [1:0] rr;
		r = 1'b0;
		@(posedge clk_i);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!r) begin
			@(negedge clk_i);
			ar = s_axi_arready;
			r = s_axi_rvalid;
			dd = s_axi_rdata;
			rr = s_axi_rresp;
			@(posedge clk_i);
			if (ar) s_axi_arvalid <= 1'b0;
		end
		s_axi_rready <= 1'b0;
		cmp("rdata", d, dd);
		cmp("rresp", e, rr);
	endtask
	task automatic wd(logic [3:0] v);
		@(negedge clk_i);
		cmp("osc", v[3], wdog_rc_osc_on_o);
		cmp("clk", v[2], wdog_clk_sel_o);
		cmp("rst", v[1], wdog_reset_en_o);
		cmp("cnt", v[0], wdog_counter_en_o);
	endtask

	// ************************************************************
	// scenarios
	// ************************************************************
	task automatic s_open();
		load(32'h69C8A273, 32'h000096D7, 32'h9D58AA04);
		cmp("level", 32'h0, prot_level_o);
		acc(2'h2, 2'h0, 2'h0, 6'h00, 1'b1);
		acc(2'h2, 2'h2, 2'h0, 6'h01, 1'b1);
		acc(2'h0, 2'h1, 2'h0, 6'h00, 1'b0);
		acc(2'h0, 2'h2, 2'h0, 6'h3F, 1'b1);
		acc(2'h0, 2'h2, 2'h0, 6'h20, 1'b0);
		acc(2'h0, 2'h1, 2'h1, 6'h07, 1'b1);
		acc(2'h0, 2'h2, 2'h1, 6'h00, 1'b0);
		acc(2'h0, 2'h1, 2'h2, 6'h01, 1'b1);
		acc(2'h0, 2'h1, 2'h2, 6'h02, 1'b0);
		rd(`OAP_A_RDPROT, 32'h69C8A273, 2'h0);
		rd(`OAP_A_DIEXY, 32'h1234ABCD, 2'h0);
		wr(`OAP_A_WDOG, 32'h0, 2'h2);
		rd(32'h1FFFF3F0, 32'h0, 2'h2);
		wd(4'h5);
		cmp("uv_en", 32'h0, undervolt_reset_en_o);
		cmp("uv_thr", 32'h4, undervolt_threshold_sel_o);
	endtask
	task automatic s_mid();
		@(posedge clk_i);
		slow <= 1'b1;
		wdog_clk_sw_sel_i <= 1'b1;
		wdog_counter_sw_enable_i <= 6'h00;
		deep_sleep_i <= 1'b1;
		load(32'h69C8A272, 32'h00002A70, 32'h9D580000);
		cmp("level", 32'h1, prot_level_o);
		acc(2'h2, 2'h0, 2'h0, 6'h01, 1'b0);
		acc(2'h2, 2'h3, 2'h0, 6'h00, 1'b1);
		acc(2'h1, 2'h2, 2'h0, 6'h01, 1'b1);
		acc(2'h2, 2'h2, 2'h0, 6'h01, 1'b0);
		acc(2'h2, 2'h1, 2'h2, 6'h01, 1'b0);
		acc(2'h2, 2'h0, 2'h2, 6'h01, 1'b1);
		wd(4'h7);
		@(posedge clk_i);
		deep_sleep_i <= 1'b0;
		wd(4'hF);
		cmp("uv_en", 32'h1, undervolt_reset_en_o);
		cmp("uv_thr", 32'h0, undervolt_threshold_sel_o);
		wr(`OAP_A_LVLREQ, 32'h2, 2'h0);
		cmp("level", 32'h2, prot_level_o);
		wr(`OAP_A_LVLREQ, 32'h1, 2'h0);
		cmp("level", 32'h2, prot_level_o);
		@(posedge clk_i);
		bulk_done_i <= 1'b1;
		@(posedge clk_i);
		bulk_done_i <= 1'b0;
		@(negedge clk_i);
		cmp("level", 32'h0, prot_level_o);
	endtask
	task automatic s_badkey();
		@(posedge clk_i);
		slow <= 1'b0;
		deep_sleep_i <= 1'b1;
		load(32'h69C8A263, 32'h00001230, 32'h1234AA04);
		cmp("level", 32'h2, prot_level_o);
		acc(2'h1, 2'h2, 2'h0, 6'h01, 1'b0);
		acc(2'h1, 2'h3, 2'h0, 6'h01, 1'b1);
		acc(2'h1, 2'h0, 2'h0, 6'h01, 1'b0);
		acc(2'h0, 2'h2, 2'h0, 6'h01, 1'b1);
		acc(2'h0, 2'h0, 2'h1, 6'h00, 1'b1);
		acc(2'h1, 2'h1, 2'h2, 6'h01, 1'b0);
		wd(4'hF);
		@(posedge clk_i);
		shutdown_i <= 1'b1;
		wd(4'h7);
		cmp("uv_en", 32'h1, undervolt_reset_en_o);
		cmp("uv_thr", 32'h7, undervolt_threshold_sel_o);
	endtask

	// inputs at time zero, then the scenarios
	initial begin
		{rst_b_i, acc_req_i, bulk_done_i, slow, deep_sleep_i} = '0;
		{shutdown_i, wdog_osc_sw_enable_i, wdog_clk_sw_sel_i} = '0;
		{undervolt_sw_enable_i, s_axi_awvalid, s_axi_wvalid} = '0;
		{s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{acc_src_i, acc_op_i, acc_area_i, acc_sect_i} = '0;
		{s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
		wdog_reset_sw_enable_i = 6'h00;
		wdog_counter_sw_enable_i = 6'h20;
		s_axi_wstrb = 4'hF;
		fl_u.mem[`OAP_A_DIEXY] = 32'h1234ABCD;
		fl_u.mem[`OAP_A_PGPROT] = 32'h00000005;
		fl_u.mem[`OAP_A_CSLO] = 32'h00000002;
		fl_u.mem[`OAP_A_CSHI] = 32'h80000000;
		fl_u.mem[`OAP_A_DSPROT] = 32'h00000080;
		s_open();
		s_mid();
		s_badkey();
		complete_run();
	end
endmodule // tb
